// ===== sap_pkg.sv
`default_nettype none

package sap_pkg;

  // ****************************************
  // register byte offsets
  // ****************************************
  localparam logic [7:0] SAP_CTRL_OFS   = 8'h00;  // control
  localparam logic [7:0] SAP_CLKDIV_OFS = 8'h04;  // clock dividers
  localparam logic [7:0] SAP_STATUS_OFS = 8'h08;  // status, sticky flags
  localparam logic [7:0] SAP_TXDATA_OFS = 8'h0c;  // transmit sample push
  localparam logic [7:0] SAP_RXDATA_OFS = 8'h10;  // receive sample pop

  // ****************************************
  // field layouts and reset values
  // ****************************************
  typedef enum logic [1:0] {SAP_W16, SAP_W24, SAP_W32, SAP_WRSV} sap_width_t;

  typedef struct packed {
    logic [25:0] rsvd;      // reads as zero
    logic        mclkEn;    // drive master clock pin
    sap_width_t  widthSel;  // sample resolution
    logic        leftJust;  // no one-bit delay after word select
    logic        master;    // drive bit clock and word select
    logic        enable;    // run the serial engine
  } sap_ctrl_t;

  typedef struct packed {
    logic [15:0] rsvd;      // reads as zero
    logic [7:0]  bclkDiv;   // bit clock half period minus one, in mclk periods
    logic [7:0]  mclkDiv;   // mclk half period minus one, in clk cycles
  } sap_clkdiv_t;

  typedef struct packed {
    logic        right;     // channel: 1 right, 0 left
    logic [31:0] sample;    // msb-aligned two's complement sample
  } sap_word_t;

  localparam logic [31:0] SAP_CTRL_RST    = 32'h0000_0000;
  localparam logic [31:0] SAP_CTRL_WMASK  = 32'h0000_003f;
  localparam logic [31:0] SAP_CLKDIV_RST  = 32'h0000_0101;
  localparam logic [31:0] SAP_CLKDIV_MASK = 32'h0000_ffff;
  localparam logic [2:0]  SAP_HSIZE_WORD  = 3'h2;

  // status bit positions
  localparam int SAP_ST_TX_FULL  = 0;
  localparam int SAP_ST_TX_EMPTY = 1;
  localparam int SAP_ST_RX_VALID = 2;
  localparam int SAP_ST_RX_RIGHT = 3;
  localparam int SAP_ST_UNDERRUN = 4;
  localparam int SAP_ST_OVERRUN  = 5;
  localparam int SAP_ST_WS       = 6;

  // bit counts
  localparam logic [5:0] SAP_BITS_16 = 6'h10;
  localparam logic [5:0] SAP_BITS_24 = 6'h18;
  localparam logic [5:0] SAP_BITS_32 = 6'h20;

  // ****************************************
  // width decoding
  // ****************************************
  function automatic logic [5:0] sap_word_bits(sap_width_t w);
    case (w)
      SAP_W16: sap_word_bits = SAP_BITS_16;
      SAP_W24: sap_word_bits = SAP_BITS_24;
      default: sap_word_bits = SAP_BITS_32;
    endcase
  endfunction : sap_word_bits

  function automatic logic [5:0] sap_slot_bits(sap_width_t w);
    sap_slot_bits = (w == SAP_W16) ? SAP_BITS_16 : SAP_BITS_32;
  endfunction : sap_slot_bits

  // keeps the top word bits of an msb-aligned sample
  function automatic logic [31:0] sap_width_mask(sap_width_t w);
    sap_width_mask = ~(32'hffff_ffff >> sap_word_bits(w));
  endfunction : sap_width_mask

endpackage : sap_pkg

`default_nettype wire

// ===== sap_fifo.sv
`timescale 1ns/10ps
`default_nettype none

module sap_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 16  // power of two
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rst_n,
  // filling side
  input  wire logic             inVal,
  output logic                  inRdy,
  input  wire logic [WIDTH-1:0] inData,
  // draining side
  output logic                  outVal,
  input  wire logic             outRdy,
  output logic [WIDTH-1:0]      outData
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];  // storage
  logic [AW-1:0]    wrPtr;        // next slot to fill
  logic [AW-1:0]    rdPtr;        // oldest word
  logic [AW:0]      count;        // words held
  logic             push;
  logic             pop;

  // honest full and empty
  assign inRdy   = count != (AW + 1)'(DEPTH);
  assign outVal  = count != '0;
  assign outData = mem[rdPtr];
  assign push    = inVal & inRdy;
  assign pop     = outVal & outRdy;

  // storage write
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wrPtr] <= inData;
    end
  end

  // pointers and fill level
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wrPtr <= '0;
      rdPtr <= '0;
      count <= '0;
    end else begin
      if (push) wrPtr <= wrPtr + 1'b1;
      if (pop) rdPtr <= rdPtr + 1'b1;
      count <= count + (AW + 1)'(push) - (AW + 1)'(pop);
    end
  end

endmodule : sap_fifo

`default_nettype wire

// ===== sap_clk_div.sv
`timescale 1ns/10ps
`default_nettype none

module sap_clk_div (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // configuration
  input  wire logic       mclkOn,
  input  wire logic       bclkOn,
  input  wire logic [7:0] mclkDiv,
  input  wire logic [7:0] bclkDiv,
  // clocks out and bit clock events
  output logic            mclkPin,
  output logic            bclkPin,
  output logic            bclkRise,
  output logic            bclkFall
);

  logic [7:0] mCnt;     // clk cycles in mclk half period
  logic [7:0] bCnt;     // mclk periods in bclk half period
  logic       mclkReg;  // internal master clock
  logic       mWrap;
  logic       mTick;
  logic       bWrap;

  assign mWrap    = mCnt == mclkDiv;
  assign mTick    = mWrap & ~mclkReg;  // master clock rising
  assign bWrap    = mTick & (bCnt == bclkDiv);
  assign bclkRise = bclkOn & bWrap & ~bclkPin;
  assign bclkFall = bclkOn & bWrap & bclkPin;

  // master clock divider, its own counter
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mCnt    <= '0;
      mclkReg <= 1'b0;
    end else if (!(mclkOn | bclkOn)) begin
      mCnt    <= '0;
      mclkReg <= 1'b0;
    end else if (mWrap) begin
      mCnt    <= '0;
      mclkReg <= ~mclkReg;
    end else begin
      mCnt <= mCnt + 8'h01;
    end
  end

  // pin copy only while the pin is wanted
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mclkPin <= 1'b0;
    end else begin
      mclkPin <= mclkOn & (mWrap ? ~mclkReg : mclkReg);
    end
  end

  // bit clock divided from master clock; at most clk/4, well under 12.288 MHz
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bCnt    <= '0;
      bclkPin <= 1'b0;
    end else if (!bclkOn) begin
      bCnt    <= '0;
      bclkPin <= 1'b0;
    end else if (mTick) begin
      if (bCnt == bclkDiv) begin
        bCnt    <= '0;
        bclkPin <= ~bclkPin;
      end else begin
        bCnt <= bCnt + 8'h01;
      end
    end
  end

  // while bclkOn stays set, the bit clock only moves on a master clock rise
  a_bclk_from_mclk : assert property (@(posedge clk) disable iff (!rst_n)
    ($changed(bclkPin) && $past(bclkOn) && bclkOn) |-> $past(mTick))
    else $error("bit clock moved without a master clock tick");

endmodule : sap_clk_div

`default_nettype wire

// ===== sap_serial_audio_port.sv
`timescale 1ns/10ps
`default_nettype none

module sap_serial_audio_port
  import sap_pkg::*;
#(
  parameter int TX_DEPTH = 16,
  parameter int RX_DEPTH = 16
) (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  // bit clock pin
  input  wire logic        bclkIn,
  output logic             bclkOut,
  output logic             bclkOe,
  // word select pin
  input  wire logic        wsIn,
  output logic             wsOut,
  output logic             wsOe,
  // serial data and master clock
  input  wire logic        sdiIn,
  output logic             sdoOut,
  output logic             mclkOut
);

  // ****************************************
  // declarations
  // ****************************************
  sap_ctrl_t   ctrlReg;      // control register
  sap_clkdiv_t clkdivReg;    // divider register
  logic        underrunReg;  // sticky: slot sent with empty tx fifo
  logic        overrunReg;   // sticky: word lost on full rx fifo
  logic        dValid;       // data phase pending
  logic [7:0]  dAddr;        // data phase offset
  logic        dWrite;       // data phase direction
  logic        dWord;        // data phase is a whole word
  logic        rdDone;       // read data loaded
  logic        regWr;        // register write this cycle
  logic        rdLoad;       // read data loaded this cycle
  logic        txStall;      // tx fifo full holds the bus
  logic [31:0] rdMux;        // read value
  logic [31:0] statusVal;    // status view
  logic [1:0]  bclkSync;     // bit clock synchroniser
  logic [1:0]  wsSync;       // word select synchroniser
  logic [1:0]  sdiSync;      // data synchroniser
  logic        bclkSyncD;    // edge detect delay
  logic        divRise;
  logic        divFall;
  logic        riseEv;       // bit clock rising
  logic        fallEv;       // bit clock falling
  logic        slaveResync;  // slave saw select move
  logic [4:0]  bitCnt;       // bit position in slot
  logic        wsReg;        // current channel
  logic [5:0]  wordBits;
  logic [5:0]  slotBits;
  logic [5:0]  slotM1;
  logic [4:0]  slotLast;
  logic [4:0]  delayCnt;     // framing delay in bits
  logic [4:0]  cntNext;
  logic        wsNew;
  logic        txLoad;       // first bit of a word goes out
  logic [31:0] txSh;         // transmit shifter
  logic        sdoReg;
  logic [31:0] txWord;
  logic        txInRdy;
  logic        txOutVal;
  logic [31:0] txOutData;
  logic [4:0]  rxIdx;        // bit index in received word
  logic        rxTake;
  logic        rxLast;
  logic [31:0] rxBit;
  logic [31:0] rxSh;         // receive shifter
  logic [31:0] rxShNext;
  logic        rxChan;       // channel of word being received
  logic        rxInRdy;
  logic        rxOutVal;
  sap_word_t   rxWord;
  sap_word_t   rxOutData;

  // ****************************************
  // bus slave
  // ****************************************

  // address phase capture, held while a data phase waits
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dValid <= 1'b0;
      dAddr  <= '0;
      dWrite <= 1'b0;
      dWord  <= 1'b0;
    end else if (hready) begin
      dValid <= hsel & htrans[1];
      dAddr  <= haddr[7:0];
      dWrite <= hwrite;
      dWord  <= hsize == SAP_HSIZE_WORD;
    end
  end

  assign txStall   = dValid & dWrite & dWord & (dAddr == SAP_TXDATA_OFS) & ~txInRdy;
  assign rdLoad    = dValid & ~dWrite & ~rdDone;
  assign hreadyout = ~(txStall | rdLoad);  // reads take one wait state
  assign hresp     = 1'b0;
  assign regWr     = dValid & dWrite & dWord;

  // read data register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdDone <= 1'b0;
      hrdata <= '0;
    end else begin
      rdDone <= rdLoad;
      if (rdLoad) hrdata <= rdMux;
    end
  end

  // status view
  always_comb begin
    statusVal                  = 32'h0;
    statusVal[SAP_ST_TX_FULL]  = ~txInRdy;
    statusVal[SAP_ST_TX_EMPTY] = ~txOutVal;
    statusVal[SAP_ST_RX_VALID] = rxOutVal;
    statusVal[SAP_ST_RX_RIGHT] = rxOutVal & rxOutData.right;
    statusVal[SAP_ST_UNDERRUN] = underrunReg;
    statusVal[SAP_ST_OVERRUN]  = overrunReg;
    statusVal[SAP_ST_WS]       = wsReg;
  end

  // read decode, unmapped reads zero
  always_comb begin
    case (dAddr)
      SAP_CTRL_OFS:   rdMux = ctrlReg;
      SAP_CLKDIV_OFS: rdMux = clkdivReg;
      SAP_STATUS_OFS: rdMux = statusVal;
      SAP_RXDATA_OFS: rdMux = rxOutVal ? rxOutData.sample : 32'h0;
      default:        rdMux = 32'h0;
    endcase
  end

  // configuration registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrlReg   <= sap_ctrl_t'(SAP_CTRL_RST);
      clkdivReg <= sap_clkdiv_t'(SAP_CLKDIV_RST);
    end else if (regWr) begin
      if (dAddr == SAP_CTRL_OFS) ctrlReg <= sap_ctrl_t'(hwdata & SAP_CTRL_WMASK);
      if (dAddr == SAP_CLKDIV_OFS) clkdivReg <= sap_clkdiv_t'(hwdata & SAP_CLKDIV_MASK);
    end
  end

  // sticky flags, set wins over write-one clear
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      underrunReg <= 1'b0;
      overrunReg  <= 1'b0;
    end else begin
      underrunReg <= (txLoad & ~txOutVal)
                   | (underrunReg & ~(regWr & (dAddr == SAP_STATUS_OFS) & hwdata[SAP_ST_UNDERRUN]));
      overrunReg  <= (rxLast & ~rxInRdy)
                   | (overrunReg & ~(regWr & (dAddr == SAP_STATUS_OFS) & hwdata[SAP_ST_OVERRUN]));
    end
  end

  // ****************************************
  // sample fifos
  // ****************************************
  sap_fifo #(.WIDTH(32), .DEPTH(TX_DEPTH)) u_tx_fifo (
    .clk     (clk),
    .rst_n   (rst_n),
    .inVal   (regWr & (dAddr == SAP_TXDATA_OFS)),
    .inRdy   (txInRdy),
    .inData  (hwdata),
    .outVal  (txOutVal),
    .outRdy  (txLoad),
    .outData (txOutData)
  );

  sap_fifo #(.WIDTH(33), .DEPTH(RX_DEPTH)) u_rx_fifo (
    .clk     (clk),
    .rst_n   (rst_n),
    .inVal   (rxLast),
    .inRdy   (rxInRdy),
    .inData  (rxWord),
    .outVal  (rxOutVal),
    .outRdy  (rdLoad & (dAddr == SAP_RXDATA_OFS)),
    .outData (rxOutData)
  );

  // ****************************************
  // clocks and pin synchronisers
  // ****************************************
  sap_clk_div u_clk_div (
    .clk      (clk),
    .rst_n    (rst_n),
    .mclkOn   (ctrlReg.enable & ctrlReg.mclkEn),
    .bclkOn   (ctrlReg.enable & ctrlReg.master),
    .mclkDiv  (clkdivReg.mclkDiv),
    .bclkDiv  (clkdivReg.bclkDiv),
    .mclkPin  (mclkOut),
    .bclkPin  (bclkOut),
    .bclkRise (divRise),
    .bclkFall (divFall)
  );

  // two flops on every pin input; slave follows an imposed bit clock only while each of its levels lasts over one clk cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bclkSync  <= '0;
      wsSync    <= '0;
      sdiSync   <= '0;
      bclkSyncD <= 1'b0;
    end else begin
      bclkSync  <= {bclkSync[0], bclkIn};
      wsSync    <= {wsSync[0], wsIn};
      sdiSync   <= {sdiSync[0], sdiIn};
      bclkSyncD <= bclkSync[1];
    end
  end

  // edge events from own divider or from the far master
  assign riseEv = ctrlReg.enable & (ctrlReg.master ? divRise : (bclkSync[1] & ~bclkSyncD));
  assign fallEv = ctrlReg.enable & (ctrlReg.master ? divFall : (~bclkSync[1] & bclkSyncD));

  // only the master drives clock and select
  assign bclkOe = ctrlReg.enable & ctrlReg.master;
  assign wsOe   = ctrlReg.enable & ctrlReg.master;
  assign wsOut  = wsReg;
  assign sdoOut = sdoReg;

  // ****************************************
  // frame counter
  // ****************************************
  assign wordBits    = sap_word_bits(ctrlReg.widthSel);
  assign slotBits    = sap_slot_bits(ctrlReg.widthSel);
  assign slotM1      = slotBits - 6'd1;
  assign slotLast    = slotM1[4:0];
  assign delayCnt    = ctrlReg.leftJust ? 5'd0 : 5'd1;
  assign cntNext     = (bitCnt == slotLast) ? 5'd0 : bitCnt + 5'd1;
  assign wsNew       = (bitCnt == slotLast) ? ~wsReg : wsReg;
  assign slaveResync = riseEv & ~ctrlReg.master & (wsSync[1] != wsReg);

  // select moves on falling edge; slave realigns on rising edge
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bitCnt <= '0;
      wsReg  <= 1'b0;
    end else if (!ctrlReg.enable) begin
      bitCnt <= '0;
      wsReg  <= 1'b0;
    end else if (fallEv) begin
      bitCnt <= cntNext;
      wsReg  <= wsNew;
    end else if (slaveResync) begin
      bitCnt <= '0;
      wsReg  <= wsSync[1];
    end
  end

  // ****************************************
  // transmitter
  // ****************************************
  assign txLoad = fallEv & (cntNext == delayCnt);
  assign txWord = txOutVal ? (txOutData & sap_width_mask(ctrlReg.widthSel)) : 32'h0;

  // msb first, zeros shift in behind the sample
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      txSh   <= '0;
      sdoReg <= 1'b0;
    end else if (!ctrlReg.enable) begin
      txSh   <= '0;
      sdoReg <= 1'b0;
    end else if (txLoad) begin
      sdoReg <= txWord[31];
      txSh   <= {txWord[30:0], 1'b0};
    end else if (fallEv) begin
      sdoReg <= txSh[31];
      txSh   <= {txSh[30:0], 1'b0};
    end
  end

  // ****************************************
  // receiver
  // ****************************************
  assign rxIdx    = (bitCnt < delayCnt) ? slotLast : bitCnt - delayCnt;
  assign rxTake   = riseEv & ({1'b0, rxIdx} < wordBits);
  assign rxLast   = riseEv & ({1'b0, rxIdx} == (wordBits - 6'd1));
  assign rxBit    = {sdiSync[1], 31'h0} >> rxIdx;
  assign rxShNext = ((rxIdx == 5'd0) ? 32'h0 : rxSh) | rxBit;
  assign rxWord   = '{right: rxChan, sample: rxShNext};

  // sample data on rising edge, low bits left zero
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rxSh   <= '0;
      rxChan <= 1'b0;
    end else if (!ctrlReg.enable) begin
      rxSh   <= '0;
      rxChan <= 1'b0;
    end else if (rxTake) begin
      rxSh <= rxShNext;
      if (rxIdx == 5'd0) rxChan <= wsReg;
    end
  end

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_master_steady;
    ctrlReg.master && ctrlReg.enable && $stable(ctrlReg);
  endsequence

  sequence s_read_phase;
    dValid && !dWrite && !rdDone;
  endsequence

  a_ws_on_fall : assert property (s_master_steady ##0 $changed(wsReg) |-> $past(fallEv))
    else $error("word select moved off a falling edge");

  a_ws_half_frame : assert property (s_master_steady ##0 $changed(wsReg) |-> $past(bitCnt) == slotLast)
    else $error("word select toggled before slot end");

  a_sdo_on_fall : assert property ($changed(sdoReg) && $past(ctrlReg.enable) |-> $past(fallEv))
    else $error("data changed off a falling edge");

  a_msb_delay : assert property (txLoad && !ctrlReg.leftJust |-> bitCnt == 5'd0 ##1 wsReg == $past(wsReg))
    else $error("msb not one bit after select change");

  a_lj_pad : assert property (txLoad && ctrlReg.widthSel == SAP_W24 |=> txSh[8:0] == 9'h000)
    else $error("24-bit sample not zero padded");

  a_rx_word : assert property (rxLast |-> riseEv && (rxShNext & ~sap_width_mask(ctrlReg.widthSel)) == 32'h0)
    else $error("received word not zero filled");

  a_slave_quiet : assert property (!ctrlReg.master |-> !bclkOe && !wsOe)
    else $error("slave drives clock or select");

  a_read_wait : assert property (s_read_phase |-> !hreadyout ##1 hreadyout)
    else $error("read wait state wrong");

  a_tx_stall : assert property (txStall |-> !hreadyout && !txInRdy)
    else $error("full tx fifo did not hold the bus");

endmodule : sap_serial_audio_port

`default_nettype wire

// ===== sap_codec_model.sv
`timescale 1ns/10ps
`default_nettype none

module sap_codec_model (
  // generator control
  input  wire logic        genOn,
  input  wire logic [5:0]  slot,
  input  wire logic [31:0] txL,
  input  wire logic [31:0] txR,
  input  wire logic        leftJust,
  // link pins as seen on the wire
  input  wire logic        bclk,
  input  wire logic        ws,
  input  wire logic        sdo,
  output logic             genBclk,
  output logic             genWs,
  output logic             sdi,
  // captured words, msb aligned
  output logic [31:0]      rxL,
  output logic [31:0]      rxR,
  output logic [5:0]       halfLen
);
  logic [5:0]  gCnt;  // falls within a slot
  logic [5:0]  rCnt;  // rises within a half
  logic [31:0] sh;    // receive shift
  logic        pWs;   // select at last rise
  logic [31:0] w;     // word on the way out
  logic [31:0] cw;    // word closed at a select change
  logic [5:0]  cn;    // bits in that word
  assign w = genWs ? txR : txL;
  // left-justified: the bit seen with the select change opens the next word
  assign cw = leftJust ? sh : {sh[30:0], sdo};
  assign cn = leftJust ? rCnt : rCnt + 6'h1;
  // bit clock stands still outside frames
  initial begin
    {genBclk, genWs, sdi, gCnt, rCnt, sh, pWs, rxL, rxR, halfLen} = '0;
    forever begin
      #800;
      genBclk = genOn ? ~genBclk : 1'b0;
    end
  end
  // launch on fall, msb one bit after the select change
  always @(negedge bclk) begin
    if (genOn) begin
      sdi <= w[5'd31 - gCnt[4:0]];
      if (gCnt == slot - 6'h1) begin
        gCnt  <= 6'h0;
        genWs <= ~genWs;
      end else begin
        gCnt <= gCnt + 6'h1;
      end
    end else begin
      sdi <= ~sdi;  // released line wanders
    end
  end
  // capture on rise, a word closes at the select change
  always @(posedge bclk) begin
    if (ws != pWs) begin
      if (pWs) rxR <= cw << (6'd32 - cn);
      else rxL <= cw << (6'd32 - cn);
      halfLen <= cn;
      rCnt    <= leftJust ? 6'h1 : 6'h0;
      sh      <= leftJust ? {31'h0, sdo} : 32'h0;
    end else begin
      sh   <= {sh[30:0], sdo};
      rCnt <= rCnt + 6'h1;
    end
    pWs <= ws;
  end
endmodule : sap_codec_model

`default_nettype wire

// ===== sap_serial_audio_port_test.sv
`timescale 1ns/10ps
`default_nettype none

module sap_serial_audio_port_test
  import sap_pkg::*;
();
  typedef struct packed {logic wr; logic [7:0] a; logic [31:0] d; logic [31:0] e;} sap_row_t;
  logic        clk, rst_n, hwrite, hreadyout, hresp, genOn, genBclk, genWs, sdi;
  logic        bclkOut, bclkOe, wsOut, wsOe, sdoOut, mclkOut, bclk, ws, leftJust;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [5:0]  slot, halfLen;
  logic [31:0] haddr, hwdata, hrdata, rd, st, txL, txR, rxL, rxR;
  int          error_cnt, checked, hi;
  sap_row_t    rows [10];
  // wire levels from the port's output enables
  assign bclk = bclkOe ? bclkOut : genBclk;
  assign ws   = wsOe ? wsOut : genWs;

  sap_serial_audio_port i_sap_serial_audio_port (.clk(clk), .rst_n(rst_n), .hsel(1'b1), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .bclkIn(bclk), .bclkOut(bclkOut),
    .bclkOe(bclkOe), .wsIn(ws), .wsOut(wsOut), .wsOe(wsOe), .sdiIn(sdi), .sdoOut(sdoOut), .mclkOut(mclkOut));
  sap_codec_model i_sap_codec_model (.genOn(genOn), .slot(slot), .txL(txL), .txR(txR), .leftJust(leftJust),
    .bclk(bclk), .ws(ws), .sdo(sdoOut), .genBclk(genBclk), .genWs(genWs), .sdi(sdi), .rxL(rxL), .rxR(rxR),
    .halfLen(halfLen));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic test_done();
    if (error_cnt == 0 && checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : test_done

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s exp %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // waits for hready, value sampled the half cycle before the edge
  task automatic waitRdy(output logic [31:0] r);
    logic rdy;
    int   n;
    n = 0;
    do begin
      @(negedge clk);
      rdy = hreadyout;
      r   = hrdata;
      @(posedge clk);
      n++;
      if (n > 5000) begin
        error_cnt++;
        test_done();
      end
    end while (rdy !== 1'b1);
  endtask : waitRdy

  // one single word transfer, address phase then data phase
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    htrans <= 2'h2;
    haddr  <= {24'h0, a};
    hwrite <= w;
    hsize  <= SAP_HSIZE_WORD;
    waitRdy(r);
    htrans <= 2'h0;
    hwdata <= d;
    waitRdy(r);
  endtask : bus

  initial begin
    {rst_n, htrans, haddr, hwrite, hsize, hwdata, genOn, leftJust} = '0;
    hi = 0;
    slot = 6'h20;
    txL  = 32'h8123_4567;
    txR  = 32'h7edc_ba98;
    error_cnt = 0;
    checked   = 0;
    rows = '{'{1'b0, SAP_CTRL_OFS, 32'h0, SAP_CTRL_RST}, '{1'b0, SAP_CLKDIV_OFS, 32'h0, SAP_CLKDIV_RST},
      '{1'b0, SAP_STATUS_OFS, 32'h0, 32'h2}, '{1'b0, SAP_RXDATA_OFS, 32'h0, 32'h0},
      '{1'b0, 8'h14, 32'h0, 32'h0}, '{1'b1, 8'h14, 32'hffff_ffff, 32'h0}, '{1'b0, 8'h14, 32'h0, 32'h0},
      '{1'b1, SAP_CLKDIV_OFS, 32'hffff_ffff, 32'h0}, '{1'b0, SAP_CLKDIV_OFS, 32'h0, SAP_CLKDIV_MASK},
      '{1'b1, SAP_CLKDIV_OFS, SAP_CLKDIV_RST, 32'h0}};
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    // reset values, masks and the unmapped place
    foreach (rows[i]) begin
      bus(rows[i].wr, rows[i].a, rows[i].d, rd);
      if (!rows[i].wr) chk("reg", rd, rows[i].e);
    end
    // master, 16 bit standard framing, tx fifo filled to full
    for (int i = 0; i < 16; i++) bus(1'b1, SAP_TXDATA_OFS, i[0] ? 32'h5a5a_ffff : 32'habcd_1234, rd);
    bus(1'b0, SAP_STATUS_OFS, 32'h0, st);
    chk("txfull", st & 32'h3, 32'h1);
    bus(1'b1, SAP_CTRL_OFS, 32'h3, rd);
    repeat (1500) @(posedge clk);
    chk("drive", {31'h0, bclkOe & wsOe}, 32'h1);
    chk("left", rxL, 32'habcd_0000);
    chk("right", rxR, 32'h5a5a_0000);
    chk("half", {26'h0, halfLen}, 32'h10);
    // drained fifo: zeros and a sticky underrun
    repeat (4000) @(posedge clk);
    bus(1'b0, SAP_STATUS_OFS, 32'h0, st);
    chk("underrun", st & 32'h33, 32'h32);
    chk("zeros", rxL, 32'h0);
    bus(1'b1, SAP_CTRL_OFS, 32'h0, rd);
    bus(1'b1, SAP_STATUS_OFS, 32'h30, rd);
    bus(1'b0, SAP_STATUS_OFS, 32'h0, st);
    chk("w1c", st & 32'h33, 32'h2);
    for (int i = 0; i < 16; i++) bus(1'b0, SAP_RXDATA_OFS, 32'h0, rd);
    // slave, 32 bit, codec drives clock and select
    bus(1'b1, SAP_CTRL_OFS, 32'h11, rd);
    genOn <= 1'b1;
    repeat (4200) @(posedge clk);
    genOn <= 1'b0;
    chk("release", {31'h0, bclkOe | wsOe}, 32'h0);
    for (int i = 0; i < 6; i++) begin
      bus(1'b0, SAP_STATUS_OFS, 32'h0, st);
      bus(1'b0, SAP_RXDATA_OFS, 32'h0, rd);
      if (i > 0) chk("rxword", rd, st[SAP_ST_RX_RIGHT] ? txR : txL);
    end
    // master, left-justified 24 bit in 32-bit slots, master clock on
    bus(1'b1, SAP_CTRL_OFS, 32'h0, rd);
    for (int i = 0; i < 4; i++) bus(1'b1, SAP_TXDATA_OFS, 32'h9abc_de5a, rd);
    leftJust <= 1'b1;
    bus(1'b1, SAP_CTRL_OFS, 32'h2f, rd);
    repeat (2400) begin
      @(negedge clk);
      if (mclkOut === 1'b1) hi++;
    end
    @(posedge clk);
    chk("mclk", hi, 32'h4b0);
    chk("ljleft", rxL, 32'h9abc_de00);
    chk("ljright", rxR, 32'h9abc_de00);
    chk("ljhalf", {26'h0, halfLen}, 32'h20);
    chk("hresp", {31'h0, hresp}, 32'h0);
    // reset in mid-run: registers, fifos and pins back to idle
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    chk("rstpins", {29'h0, bclkOe, wsOe, mclkOut}, 32'h0);
    bus(1'b0, SAP_CTRL_OFS, 32'h0, rd);
    chk("rstctrl", rd, SAP_CTRL_RST);
    bus(1'b0, SAP_STATUS_OFS, 32'h0, st);
    chk("rststat", st, 32'h2);
    test_done();
  end
endmodule : sap_serial_audio_port_test

`default_nettype wire
